// ---- bench/ldr_top_properties.sv ----
// Port checker for the lane deskew and release block.
// Assumes binding to ldr_top with one clock and its asynchronous reset.
`include "ldr_defs.svh"
module ldr_top_properties #(
   parameter int QO_DIV = 1 // Core cycles per quad-octet.
) (
   input wire logic ref_clk, // Core clock.
   input wire logic rst_n, // Reset, active low.
   input wire logic wb_cyc, // Bus cycle.
   input wire logic wb_stb, // Bus strobe.
   input wire logic wb_we, // Bus direction.
   input wire logic [7:0] wb_adr, // Bus address.
   input wire logic [31:0] wb_wdat, // Write data.
   input wire logic [3:0] wb_sel, // Byte lanes.
   input wire logic [31:0] wb_rdat, // Read data.
   input wire logic wb_ack, // Acknowledge.
   input wire logic sysref, // Timing pulse.
   input wire ldr_pkg::ldr_qo_t [`LDR_LANES-1:0] serial_rx_pair, // Pairs in.
   input wire ldr_pkg::ldr_qo_t [`LDR_LANES-1:0] rx_lane, // Lanes out.
   input wire logic [5:0] pll_ref_divider, // Divider code.
   input wire logic [7:0] pll_feedback_multiplier, // Multiplier code.
   input wire logic [1:0] pll_rate_code, // Rate code.
   input wire logic vco_range_select, // Range select.
   input wire logic link_released, // Release level.
   input wire logic irq // Interrupt.
);
   logic [1:0] up_q;
   // Edges that still see reset values are skipped by the change checks.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   end
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   property p_ack_pulse;
      wb_ack |=> !wb_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
   property p_ack_answer;
      wb_cyc && wb_stb && !wb_ack |=> wb_ack;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
   property p_ack_cause;
      $rose(wb_ack) |-> $past(wb_cyc && wb_stb);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_rdat_idle;
      !wb_ack |-> wb_rdat == 32'h0000_0000;
   endproperty
   a_rdat_idle: assert property (p_rdat_idle) else $error("read data outside ack");
   property p_lane_gate;
      rx_lane[0].valid || rx_lane[15].valid |-> link_released || $past(link_released);
   endproperty
   a_lane_gate: assert property (p_lane_gate) else $error("beat before release");
   property p_rel_data;
      $rose(link_released) |-> ##[0:3] rx_lane[0].valid;
   endproperty
   a_rel_data: assert property (p_rel_data) else $error("release without beats");
   property p_pll_write;
      up_q == 2'h3 && $changed({pll_ref_divider, pll_feedback_multiplier, pll_rate_code,
         vco_range_select}) |-> wb_ack || $past(wb_ack);
   endproperty
   a_pll_write: assert property (p_pll_write) else $error("pll code moved alone");
   property p_irq_fall;
      up_q == 2'h3 && $fell(irq) |-> wb_ack || $past(wb_ack);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
   c_release: cover property ($rose(link_released));
   c_irq: cover property ($rose(irq));
   c_write: cover property (wb_ack && wb_we);
endmodule

// ---- bench/ldr_tx_model.sv ----
// Transmitter model: quad-octet beats on all sixteen pairs.
// Assumes the receiver's core clock; go starts the lane blocks.
`include "ldr_defs.svh"
module ldr_tx_model (
   input wire logic clk, // Core clock.
   input wire logic go, // Starts block traffic.
   output ldr_pkg::ldr_qo_t [`LDR_LANES-1:0] pairs // Beats to the receiver.
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [27:0] free_q = 28'h000_0000;
   logic [27:0] since_q = 28'h000_0000;
   // Beats flow every edge, so arrival counters advance before blocks start.
   always_ff @(posedge clk) begin
      free_q <= free_q + 28'h1;
      since_q <= go ? since_q + 28'h1 : 28'h0;
   end
   // Pair p starts p mod 4 beats late, like board skew at a free phase.
   always_comb begin
      for (int p = 0; p < `LDR_LANES; p++) begin
         pairs[p].valid = 1'b1;
         pairs[p].blk_start = go && (since_q == 28'(p % 4));
         pairs[p].data = {4'(p), free_q}; // Pair number marks the content.
      end
   end
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench of the lane release block.
// Assumes the package, header, design files and transmitter model compile first.
`include "ldr_defs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int QO_DIV = 1;
   localparam logic [63:0] IDENT = 64'hFEDC_BA98_7654_3210;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_wdat = 32'h0000_0000;
   logic [3:0] wb_sel = 4'h0;
   logic sysref = 1'b0;
   logic go = 1'b0;
   logic [31:0] wb_rdat;
   logic wb_ack;
   ldr_pkg::ldr_qo_t [`LDR_LANES-1:0] pairs;
   ldr_pkg::ldr_qo_t [`LDR_LANES-1:0] rx_lane;
   logic [5:0] pll_ref_divider;
   logic [7:0] pll_feedback_multiplier;
   logic [1:0] pll_rate_code;
   logic vco_range_select;
   logic link_released;
   logic irq;
   logic [5:0] arr_min = 6'h00;
   int fails = 0;
   int cmp_count = 0;
   int cyc_n = 0;
   ldr_top #(.QO_DIV(QO_DIV)) ldr_top_i (.ref_clk, .rst_n, .wb_cyc, .wb_stb, .wb_we,
      .wb_adr, .wb_wdat, .wb_sel, .wb_rdat, .wb_ack, .sysref, .serial_rx_pair(pairs),
      .rx_lane, .pll_ref_divider, .pll_feedback_multiplier, .pll_rate_code,
      .vco_range_select, .link_released, .irq);
   ldr_tx_model ldr_tx_model_i (.clk(ref_clk), .go(go), .pairs(pairs));
   // Clock at 125 MHz.
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   // A hang is cut short well past the expected run length.
   always @(posedge ref_clk) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         fails++;
         summarize();
      end
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [27:0] skew(input logic [3:0] p);
      return 28'(p[1:0]);
   endfunction
   // One classic bus cycle, held until ack is sampled high.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                     output logic [31:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_wdat <= d;
      wb_sel <= 4'hF;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      r = wb_rdat;
      check(32'(wb_ack), 32'h1);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask
   // Reset, restore the stored delay and routes, align, enable, start the lanes.
   task automatic run_link(input logic [2:0] ctl, input logic [5:0] rbd,
                           input logic [63:0] sel, output int tr);
      logic [31:0] r;
      rst_n <= 1'b0;
      go <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      wb(1'b1, `LDR_OFS_RBD, 32'(rbd), r);
      wb(1'b1, `LDR_OFS_SEL_LO, sel[31:0], r);
      wb(1'b1, `LDR_OFS_SEL_HI, sel[63:32], r);
      wb(1'b1, `LDR_OFS_IRQ_EN, 32'h0000_0004, r);
      sysref <= 1'b1;
      repeat (6) @(posedge ref_clk);
      sysref <= 1'b0;
      wb(1'b1, `LDR_OFS_CTRL, 32'(ctl), r);
      go <= 1'b1;
      tr = 0;
      while (link_released !== 1'b1 && irq !== 1'b1 && tr < 300) begin
         @(posedge ref_clk);
         tr++;
      end
   endtask
   // First released beats: routed pair and lockstep entry on every lane.
   task automatic chk_data(input logic [63:0] sel);
      int n;
      logic [3:0] p;
      n = 0;
      while (rx_lane[0].valid !== 1'b1 && n < 8) begin
         @(posedge ref_clk);
         n++;
      end
      for (int j = 0; j < 16; j++) begin
         p = sel[4*j +: 4];
         check(32'({rx_lane[j].valid, rx_lane[j].data[31:28]}), 32'({1'b1, p}));
         check(32'(28'(rx_lane[j].data[27:0] - rx_lane[0].data[27:0])),
               32'(28'(skew(p) - skew(sel[3:0]))));
      end
   endtask
   task automatic t_regs();
      logic [31:0] r;
      wb(1'b0, `LDR_OFS_PLL_CFG, 32'h0000_0000, r);
      check(r, `LDR_RST_PLL);
      check(32'({pll_ref_divider, pll_feedback_multiplier, pll_rate_code}),
            32'({6'h20, 8'h21, 2'h1}));
      wb(1'b0, `LDR_OFS_PLL_STAT, 32'h0000_0000, r);
      check(r, 32'h0020_0421);
      wb(1'b0, 8'h3C, 32'h0000_0000, r);
      check(r, 32'h0000_0000);
      wb(1'b0, `LDR_OFS_LANE_EN, 32'h0000_0000, r);
      check(r, 32'h0000_FFFF);
   endtask
   // Every rate code, with its factor in halves.
   task automatic t_pll();
      logic [31:0] r;
      for (int c = 0; c < 4; c++) begin
         wb(1'b1, `LDR_OFS_PLL_CFG, {7'h0, c[0], 6'h0, 2'(c), 8'h21, 8'h30}, r);
         wb(1'b0, `LDR_OFS_PLL_STAT, 32'h0000_0000, r);
         check(r, {10'h0, 6'h30, 4'h0, 4'h8 >> c, 8'h21});
         check(32'(pll_rate_code), 32'(c));
         check(32'(vco_range_select), 32'(c[0]));
      end
   endtask
   // Mirrored routes without a delay: arrivals and automatic release.
   task automatic t_sc0();
      int tr;
      logic [31:0] r;
      logic [31:0] a0;
      run_link(3'h3, 6'h3F, 64'h0123_4567_89AB_CDEF, tr);
      check(32'(tr <= 8), 32'h1);
      chk_data(64'h0123_4567_89AB_CDEF);
      for (int i = 0; i < 16; i++) begin
         wb(1'b0, 8'h40 + 8'(4 * i), 32'h0000_0000, r);
         if (i == 0) a0 = r;
         if (i == 15) arr_min = r[5:0];
         check(32'(6'(r[5:0] - a0[5:0])), 32'(6'(skew(4'(15 - i)) - 28'h3)));
      end
   endtask
   // Delay at the last usable entry and one past it, at both depths.
   task automatic t_window();
      int tr;
      logic [31:0] r;
      logic [5:0] dep;
      for (int k = 0; k < 4; k++) begin
         dep = k[1] ? 6'h08 : 6'h10;
         run_link({k[1], 2'h1}, arr_min + dep + 6'(k[0]), IDENT, tr);
         check(32'(link_released), 32'(!k[0]));
         check(32'(irq), 32'(k[0]));
         if (k[0]) begin
            wb(1'b0, `LDR_OFS_IRQ_STAT, 32'h0000_0000, r);
            check(32'(r[2]), 32'h1);
            wb(1'b1, `LDR_OFS_IRQ_CLR, 32'h0000_0004, r);
            repeat (2) @(posedge ref_clk);
            check(32'(irq), 32'h0);
         end else begin
            chk_data(IDENT);
         end
      end
   endtask
   // One step of delay moves the release one tick; masking and realignment follow.
   task automatic t_rbd_step();
      int t0;
      int t1;
      logic [31:0] r;
      run_link(3'h1, arr_min + 6'h05, IDENT, t0);
      run_link(3'h1, arr_min + 6'h06, IDENT, t1);
      check(32'(t1 - t0), 32'h1);
      wb(1'b0, `LDR_OFS_IRQ_STAT, 32'h0000_0000, r);
      check(r & 32'h0000_0007, 32'h0000_0003);
      check(32'(irq), 32'h0);
      wb(1'b1, `LDR_OFS_IRQ_EN, 32'h0000_0002, r);
      repeat (2) @(posedge ref_clk);
      check(32'(irq), 32'h1);
      wb(1'b1, `LDR_OFS_IRQ_CLR, 32'h0000_0002, r);
      repeat (2) @(posedge ref_clk);
      check(32'(irq), 32'h0);
      sysref <= 1'b1;
      repeat (8) @(posedge ref_clk);
      sysref <= 1'b0;
      check(32'(link_released), 32'h0);
   endtask
   // Main sequence.
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_regs();
      t_pll();
      t_sc0();
      t_window();
      t_rbd_step();
      summarize();
   end
endmodule
bind ldr_top ldr_top_properties #(.QO_DIV(QO_DIV)) ldr_top_properties_i (.ref_clk, .rst_n,
   .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_wdat, .wb_sel, .wb_rdat, .wb_ack, .sysref,
   .serial_rx_pair, .rx_lane, .pll_ref_divider, .pll_feedback_multiplier, .pll_rate_code,
   .vco_range_select, .link_released, .irq);

// ---- hw/ldr_defs.svh ----
// Constants for the lane deskew and release block: offsets, fields, resets, counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LDR_DEFS_SVH
`define LDR_DEFS_SVH
`define LDR_LANES 16
`define LDR_SELW 4
`define LDR_QW 32
`define LDR_EB_DEPTH 16
`define LDR_CW 6
`define LDR_OFS_CTRL 8'h00
`define LDR_OFS_RBD 8'h04
`define LDR_OFS_LANE_EN 8'h08
`define LDR_OFS_SEL_LO 8'h0C
`define LDR_OFS_SEL_HI 8'h10
`define LDR_OFS_PLL_CFG 8'h14
`define LDR_OFS_PLL_STAT 8'h18
`define LDR_OFS_IRQ_STAT 8'h1C
`define LDR_OFS_IRQ_EN 8'h20
`define LDR_OFS_IRQ_CLR 8'h24
`define LDR_OFS_LINK_STAT 8'h28
`define LDR_ARR_PAGE 2'h1
`define LDR_CTRL_EN 0
`define LDR_CTRL_SC0 1
`define LDR_CTRL_KF32 2
`define LDR_PLL_PLL_REF_DIVIDER_LSB 0
`define LDR_PLL_MPY_LSB 8
`define LDR_PLL_RATE_LSB 16
`define LDR_PLL_VR_BIT 24
`define LDR_IRQ_SYSREF 0
`define LDR_IRQ_REL 1
`define LDR_IRQ_OVF 2
`define LDR_RST_CTRL 3'h0
`define LDR_RST_RBD 6'h00
`define LDR_RST_LANE_EN 16'hFFFF
`define LDR_RST_SEL 64'hFEDC_BA98_7654_3210
`define LDR_RST_PLL 32'h0001_2120
`define LDR_RATE0_X2 4'h8
`define LDR_RATE1_X2 4'h4
`define LDR_RATE2_X2 4'h2
`define LDR_RATE3_X2 4'h1
`endif

// ---- hw/ldr_ebuf.sv ----
// Elastic buffer of one lane, quad-octet entries, depth halved on request.
// Assumes reads come in lockstep from the release sequencer.
module ldr_ebuf #(
   parameter int W = 34,
   parameter int DEPTH = 16
) (
   input wire logic clk, // Core clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic flush, // Empties the buffer.
   input wire logic half, // Usable depth is half of DEPTH.
   input wire logic wr, // Write one entry.
   input wire logic [W-1:0] wdata, // Entry to write.
   input wire logic rd, // Read one entry.
   output logic [W-1:0] rdata_q, // Entry read, zero when none.
   output logic ovf // Write refused for lack of room.
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d, lim;
   logic wr_ok, rd_ok;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p, input logic [AW:0] l);
      bump = ({1'b0, p} == l - (AW+1)'(1)) ? '0 : p + AW'(1);
   endfunction

   // A write into a full buffer is fine when the same entry is read out this cycle.
   always_comb begin
      lim = half ? (AW+1)'(DEPTH/2) : (AW+1)'(DEPTH);
      rd_ok = rd && (cnt_q != '0);
      wr_ok = wr && ((cnt_q != lim) || rd_ok);
      ovf = wr && !wr_ok;
      wp_d = wr_ok ? bump(wp_q, lim) : wp_q;
      rp_d = rd_ok ? bump(rp_q, lim) : rp_q;
      cnt_d = cnt_q + (AW+1)'(wr_ok) - (AW+1)'(rd_ok);
      if (flush) begin
         wp_d = '0;
         rp_d = '0;
         cnt_d = '0;
      end
   end

   // Pointers, fill count and read register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         rdata_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
         rdata_q <= rd_ok ? mem[rp_q] : '0;
      end
   end

   // Storage has no reset; nothing is read before it is written.
   always_ff @(posedge clk) begin
      if (wr_ok && !flush) begin
         mem[wp_q] <= wdata;
      end
   end
endmodule

// ---- hw/ldr_pkg.sv ----
// Types shared by the lane deskew and release block.
// Assumes ldr_defs.svh is on the include path.
`include "ldr_defs.svh"
package ldr_pkg;
   // One quad-octet beat of a lane, with the start-of-block marker.
   typedef struct packed {
      logic valid;
      logic blk_start;
      logic [`LDR_QW-1:0] data;
   } ldr_qo_t;
   // Release sequencer states.
   typedef enum logic [1:0] {RS_IDLE, RS_WAIT, RS_RUN} ldr_rel_t;
endpackage

// ---- hw/ldr_top.sv ----
// Lane mapping, arrival timing and deterministic elastic buffer release.
// Assumes deserialized lanes on ref_clk, sysref from a pin, a classic Wishbone master.
// Summary of operation
// - PLL multiplier code counts quarters, 0x21 is 8.25; rate 1 gives 2, 0 gives 4.
// - A crossbar after the receive layer routes any pair to any logical lane.
// - Pairs map to the lanes the packing format expects; transmitter drives accordingly.
// - Captured SYSREF resets the local multiframe counter.
// - Release sits RBD quad-octets after the multiframe edge; zero is the edge.
// - A release chance comes each multiframe but waits for all active lanes.
// - Each lane keeps a modulo-64 counter stepping per received quad-byte.
// - SYSREF clears and aligns the per-lane arrival counters.
// - Software reads an arrival time for every lane.
// - Buffers hold 16 quad-octets, only 8 when K times F is 32.
// - Writing the entry being read out in that cycle is not overflow.
// - Operation holds only for phases that put every lane's arrival within the buffer depth before the release point.
// - This end receives; the far logic device transmits the serial lanes.
// - Without SYSREF, free-running multiframe; with SC0 set, release right after the last lane.
// - Overflow on any used lane resets the whole link layer.
`include "ldr_defs.svh"
module ldr_top #(
   parameter int QO_DIV = 1 // Core cycles per quad-octet period.
) (
   input wire logic ref_clk, // Core clock, 125 MHz.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic wb_cyc, // Wishbone cycle.
   input wire logic wb_stb, // Wishbone strobe.
   input wire logic wb_we, // Wishbone write enable.
   input wire logic [7:0] wb_adr, // Wishbone byte address.
   input wire logic [31:0] wb_wdat, // Wishbone write data.
   input wire logic [3:0] wb_sel, // Wishbone byte lanes.
   output logic [31:0] wb_rdat, // Wishbone read data.
   output logic wb_ack, // Wishbone acknowledge.
   input wire logic sysref, // SYSREF pin, asynchronous.
   input wire ldr_pkg::ldr_qo_t [`LDR_LANES-1:0] serial_rx_pair, // Deserialized pairs.
   output ldr_pkg::ldr_qo_t [`LDR_LANES-1:0] rx_lane, // Released logical lanes.
   output logic [5:0] pll_ref_divider, // PLL reference divider code.
   output logic [7:0] pll_feedback_multiplier, // PLL multiplier code.
   output logic [1:0] pll_rate_code, // PLL rate code.
   output logic vco_range_select, // VCO range select.
   output logic link_released, // Buffers are released.
   output logic irq // Level interrupt.
);
   localparam int L = `LDR_LANES;
   localparam int CW = `LDR_CW;
   localparam int QOW = $bits(ldr_pkg::ldr_qo_t);
   localparam int DW = (QO_DIV > 1) ? $clog2(QO_DIV) : 1;

   ldr_pkg::ldr_qo_t [L-1:0] lane;
   ldr_pkg::ldr_rel_t st_q, st_d;
   logic s1_q, s2_q, s3_q, slvl_q, slvl_d, sysref_ev;
   logic [DW-1:0] div_q, div_d;
   logic qo_tick;
   logic [CW-1:0] lmfc_q, lmfc_d;
   logic [CW-1:0] lcnt_q [L];
   logic [CW-1:0] lcnt_d [L];
   logic [CW-1:0] arr_q [L];
   logic [CW-1:0] arr_d [L];
   logic [L-1:0] live_q, live_d, wr, ovf, start;
   logic link_rst, link_hold, realign, all_arr, rd_all, rel_pulse, ovf_any;
   logic [2:0] ctrl_q, ctrl_d, ien_q, ien_d, ist_q, ist_d, ev;
   logic [5:0] rbd_q, rbd_d;
   logic [15:0] len_q, len_d;
   logic [63:0] sel_q, sel_d;
   logic [31:0] pll_q, pll_d, rdat_d;
   logic ack_d, acc, wacc, irq_d;

   // Multiplier code is in quarters; rate code doubles per step down.
   function automatic logic [31:0] pll_stat(input logic [31:0] cfg);
      logic [3:0] rx2;
      unique case (cfg[`LDR_PLL_RATE_LSB +: 2])
         2'h0: rx2 = `LDR_RATE0_X2;
         2'h1: rx2 = `LDR_RATE1_X2;
         2'h2: rx2 = `LDR_RATE2_X2;
         2'h3: rx2 = `LDR_RATE3_X2;
      endcase
      pll_stat = {10'h000, cfg[`LDR_PLL_PLL_REF_DIVIDER_LSB +: 6], 4'h0, rx2,
                  cfg[`LDR_PLL_MPY_LSB +: 8]};
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
      for (int b = 0; b < 4; b++) begin
         wmerge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
      end
   endfunction

   ldr_xbar #(.LANES(L), .SELW(`LDR_SELW)) u_xbar (
      .clk(ref_clk),
      .rst_n(rst_n),
      .phys(serial_rx_pair),
      .sel(sel_q),
      .lane_q(lane)
   );

   // SYSREF: three stages, a rise counts once the second and third agree.
   always_comb begin
      slvl_d = (s2_q == s3_q) ? s3_q : slvl_q;
      sysref_ev = s2_q && s3_q && !slvl_q;
      div_d = (div_q == DW'(QO_DIV - 1)) ? '0 : div_q + DW'(1);
      qo_tick = (div_q == DW'(QO_DIV - 1));
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         slvl_q <= 1'b0;
         div_q <= '0;
      end else begin
         s1_q <= sysref;
         s2_q <= s1_q;
         s3_q <= s2_q;
         slvl_q <= slvl_d;
         div_q <= div_d;
      end
   end

   // Multiframe and per-lane counters. Without SYSREF the multiframe counter
   // simply free-runs from reset, so its phase is arbitrary.
   always_comb begin
      lmfc_d = sysref_ev ? '0 : (qo_tick ? lmfc_q + CW'(1) : lmfc_q);
      realign = sysref_ev && (lmfc_q != '0);
      // Buffer access is gated without the overflow term, which would close a loop.
      link_hold = !ctrl_q[`LDR_CTRL_EN] || realign;
      ovf_any = |(ovf & len_q);
      link_rst = link_hold || ovf_any;
      for (int i = 0; i < L; i++) begin
         lcnt_d[i] = lcnt_q[i];
         if (sysref_ev) begin
            lcnt_d[i] = '0;
         end else if (lane[i].valid) begin
            lcnt_d[i] = lcnt_q[i] + CW'(1);
         end
         start[i] = len_q[i] && lane[i].valid && lane[i].blk_start && !live_q[i]
                    && (st_q != ldr_pkg::RS_IDLE);
         live_d[i] = link_rst ? 1'b0 : (live_q[i] || start[i]);
         arr_d[i] = start[i] ? lcnt_q[i] : arr_q[i];
         wr[i] = len_q[i] && lane[i].valid && (live_q[i] || start[i]) && !link_hold;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lmfc_q <= '0;
         live_q <= '0;
         for (int i = 0; i < L; i++) begin
            lcnt_q[i] <= '0;
            arr_q[i] <= '0;
         end
      end else begin
         lmfc_q <= lmfc_d;
         live_q <= live_d;
         for (int i = 0; i < L; i++) begin
            lcnt_q[i] <= lcnt_d[i];
            arr_q[i] <= arr_d[i];
         end
      end
   end

   // Release sequencer. The release point repeats every multiframe, but a late
   // lane keeps the earliest buffer filling until it overflows and resets the link.
   always_comb begin
      all_arr = (|len_q) && (&(live_q | ~len_q));
      st_d = st_q;
      rel_pulse = 1'b0;
      unique case (st_q)
         ldr_pkg::RS_IDLE: begin
            if (!link_rst) begin
               st_d = ldr_pkg::RS_WAIT;
            end
         end
         ldr_pkg::RS_WAIT: begin
            if (ctrl_q[`LDR_CTRL_SC0]) begin
               rel_pulse = all_arr;
            end else begin
               rel_pulse = all_arr && qo_tick && (lmfc_q == rbd_q);
            end
            if (rel_pulse) begin
               st_d = ldr_pkg::RS_RUN;
            end
         end
         ldr_pkg::RS_RUN: begin
            st_d = ldr_pkg::RS_RUN;
         end
      endcase
      if (link_hold) begin
         rel_pulse = 1'b0;
      end
      if (link_rst) begin
         st_d = ldr_pkg::RS_IDLE;
      end
      // The first read falls in the release cycle itself, so at the latest usable
      // delay the earliest lane writes the very entry that is being read out.
      rd_all = ((st_q == ldr_pkg::RS_RUN) || rel_pulse) && qo_tick && !link_hold;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ldr_pkg::RS_IDLE;
         link_released <= 1'b0;
      end else begin
         st_q <= st_d;
         link_released <= (st_d == ldr_pkg::RS_RUN);
      end
   end

   // One buffer per logical lane, all enabled ones read together.
   for (genvar g = 0; g < L; g++) begin : g_eb
      ldr_ebuf #(.W(QOW), .DEPTH(`LDR_EB_DEPTH)) u_eb (
         .clk(ref_clk),
         .rst_n(rst_n),
         .flush(link_rst),
         .half(ctrl_q[`LDR_CTRL_KF32]),
         .wr(wr[g]),
         .wdata(lane[g]),
         .rd(rd_all && len_q[g]),
         .rdata_q(rx_lane[g]),
         .ovf(ovf[g])
      );
   end

   // Register file. Writes land on the edge that raises ack; RBD should be
   // restored by firmware rather than recomputed, which the block cannot enforce.
   always_comb begin
      acc = wb_cyc && wb_stb && !wb_ack;
      wacc = acc && wb_we;
      ack_d = acc;
      ctrl_d = ctrl_q;
      rbd_d = rbd_q;
      len_d = len_q;
      sel_d = sel_q;
      pll_d = pll_q;
      ien_d = ien_q;
      ev = '0;
      ev[`LDR_IRQ_SYSREF] = sysref_ev;
      ev[`LDR_IRQ_REL] = rel_pulse && !link_rst;
      ev[`LDR_IRQ_OVF] = ovf_any;
      ist_d = ist_q;
      if (wacc) begin
         unique case (wb_adr)
            `LDR_OFS_CTRL: ctrl_d = 3'(wmerge({29'h0, ctrl_q}, wb_wdat, wb_sel));
            `LDR_OFS_RBD: rbd_d = 6'(wmerge({26'h0, rbd_q}, wb_wdat, wb_sel));
            `LDR_OFS_LANE_EN: len_d = 16'(wmerge({16'h0, len_q}, wb_wdat, wb_sel));
            `LDR_OFS_SEL_LO: sel_d[31:0] = wmerge(sel_q[31:0], wb_wdat, wb_sel);
            `LDR_OFS_SEL_HI: sel_d[63:32] = wmerge(sel_q[63:32], wb_wdat, wb_sel);
            `LDR_OFS_PLL_CFG: pll_d = wmerge(pll_q, wb_wdat, wb_sel);
            `LDR_OFS_IRQ_EN: ien_d = 3'(wmerge({29'h0, ien_q}, wb_wdat, wb_sel));
            `LDR_OFS_IRQ_CLR: ist_d = ist_q & ~wb_wdat[2:0];
            default: ;
         endcase
      end
      ist_d = ist_d | ev; // A new event wins over a clear in the same cycle.
      irq_d = |(ist_d & ien_d);
      rdat_d = 32'h0000_0000;
      if (acc && !wb_we) begin
         if (wb_adr[7:6] == `LDR_ARR_PAGE) begin
            rdat_d = {26'h0, arr_q[wb_adr[5:2]]};
         end else begin
            unique case (wb_adr)
               `LDR_OFS_CTRL: rdat_d = {29'h0, ctrl_q};
               `LDR_OFS_RBD: rdat_d = {26'h0, rbd_q};
               `LDR_OFS_LANE_EN: rdat_d = {16'h0, len_q};
               `LDR_OFS_SEL_LO: rdat_d = sel_q[31:0];
               `LDR_OFS_SEL_HI: rdat_d = sel_q[63:32];
               `LDR_OFS_PLL_CFG: rdat_d = pll_q;
               `LDR_OFS_PLL_STAT: rdat_d = pll_stat(pll_q);
               `LDR_OFS_IRQ_STAT: rdat_d = {29'h0, ist_q};
               `LDR_OFS_IRQ_EN: rdat_d = {29'h0, ien_q};
               `LDR_OFS_LINK_STAT: rdat_d = {live_q, 14'h0, all_arr, link_released};
               default: rdat_d = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `LDR_RST_CTRL;
         rbd_q <= `LDR_RST_RBD;
         len_q <= `LDR_RST_LANE_EN;
         sel_q <= `LDR_RST_SEL;
         pll_q <= `LDR_RST_PLL;
         ien_q <= 3'h0;
         ist_q <= 3'h0;
         irq <= 1'b0;
         wb_ack <= 1'b0;
         wb_rdat <= 32'h0000_0000;
         pll_ref_divider <= 6'h00;
         pll_feedback_multiplier <= 8'h00;
         pll_rate_code <= 2'h0;
         vco_range_select <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         rbd_q <= rbd_d;
         len_q <= len_d;
         sel_q <= sel_d;
         pll_q <= pll_d;
         ien_q <= ien_d;
         ist_q <= ist_d;
         irq <= irq_d;
         wb_ack <= ack_d;
         wb_rdat <= rdat_d;
         pll_ref_divider <= pll_q[`LDR_PLL_PLL_REF_DIVIDER_LSB +: 6];
         pll_feedback_multiplier <= pll_q[`LDR_PLL_MPY_LSB +: 8];
         pll_rate_code <= pll_q[`LDR_PLL_RATE_LSB +: 2];
         vco_range_select <= pll_q[`LDR_PLL_VR_BIT];
      end
   end
endmodule

// ---- hw/ldr_xbar.sv ----
// Lane crossbar: each logical lane takes any physical receive pair.
// Assumes the route selects are stable while the link runs.
module ldr_xbar #(
   parameter int LANES = 16,
   parameter int SELW = 4
) (
   input wire logic clk, // Core clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire ldr_pkg::ldr_qo_t [LANES-1:0] phys, // Physical pairs.
   input wire logic [LANES*SELW-1:0] sel, // Route select per logical lane.
   output ldr_pkg::ldr_qo_t [LANES-1:0] lane_q // Logical lanes, registered.
);
   ldr_pkg::ldr_qo_t [LANES-1:0] lane_d;

   // Every logical lane picks its physical source.
   always_comb begin
      for (int i = 0; i < LANES; i++) begin
         lane_d[i] = phys[sel[i*SELW +: SELW]];
      end
   end

   // A register stage keeps the wide mux off the buffer write path.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lane_q <= '0;
      end else begin
         lane_q <= lane_d;
      end
   end
endmodule
